// >>> bench/sync_serial_codec.sv
// Serial partner that captures bits while frame sync is high
`timescale 1ns/1ps
module sync_serial_codec
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Link
	input wire logic sclk_in,
	input wire logic fs_in,
	input wire logic data_in,
	// Capture
	output logic [31:0] bits_out,
	output logic [8:0] count_out
);
	logic sclk_q;
	logic fs_q;
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sclk_q <= 1'b0;
			fs_q <= 1'b0;
			bits_out <= '0;
			count_out <= '0;
		end
		else
		begin
			sclk_q <= sclk_in;
			fs_q <= fs_in;
			if (fs_in && !fs_q)
			begin
				bits_out <= '0;
				count_out <= '0;
			end
			else if (fs_in && sclk_in && !sclk_q)
			begin
				bits_out <= {bits_out[30:0], data_in};
				count_out <= count_out + 9'h1;
			end
		end
	end
endmodule

// >>> bench/sync_serial_transmitter_test.sv
// Register and frame tests of the serial transmitter
`timescale 1ns/1ps
module sync_serial_transmitter_test;
	import sync_serial_tx_pkg::*;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	apb_req_s req = '0;
	apb_rsp_s rsp;
	logic md = 1'b0;
	logic [31:0] rw = 32'h5a3c0f01;
	logic dma;
	logic [1:0] dsz;
	logic sck;
	logic sck_oe;
	logic fs_o;
	logic fs_oe;
	logic fs_line;
	logic dat;
	logic dat_oe;
	logic [31:0] bits;
	logic [8:0] cnt;
	logic [31:0] rd;
	logic err;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	assign fs_line = fs_oe ? fs_o : 1'b0;
	always #2 clk_in = ~clk_in;
	sync_serial_transmitter sync_serial_transmitter_inst (
		.clk_in, .resetn_in, .apb_in(req), .apb_out(rsp), .rx_start_in(1'b0),
		.received_word_in(rw), .dma_req_out(dma), .dma_size_out(dsz), .rx_clock_in(1'b0),
		.tx_clock_in(1'b0), .tx_clock_out(sck), .tx_clock_oe_out(sck_oe),
		.frame_sync_in(fs_line), .frame_sync_out(fs_o), .frame_sync_oe_out(fs_oe),
		.tx_data_out(dat), .tx_data_oe_out(dat_oe), .multidrive_in(md)
	);
	sync_serial_codec sync_serial_codec_inst (
		.clk_in, .resetn_in, .sclk_in(sck), .fs_in(fs_line),
		.data_in(dat_oe ? dat : 1'b0), .bits_out(bits), .count_out(cnt)
	);
	task automatic final_report;
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_in);
		req.penable <= 1'b1;
		do
			@(posedge clk_in);
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic wait_oe(input logic v);
		do
			@(posedge clk_in);
		while (sck_oe !== v);
	endtask
	task automatic frame(input logic [31:0] fm, input logic [31:0] d, input logic two,
		input logic [8:0] n, input logic [31:0] e);
		xfer(1'b1, 8'h1c, fm);
		xfer(1'b1, 8'h24, d);
		if (two)
		begin
			do
				@(posedge clk_in);
			while (dma !== 1'b1);
			xfer(1'b1, 8'h24, d >> 8);
		end
		wait_oe(1'b1);
		wait_oe(1'b0);
		chk(cnt, n);
		chk(bits, e);
		chk(dat, fm[5]);
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			final_report();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		rdc(8'h1c, 32'h0);
		rdc(8'h18, 32'h0);
		rdc(8'h40, 32'h3);
		xfer(1'b1, 8'h20, 32'h0);
		rdc(8'h20, rw);
		xfer(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		xfer(1'b1, 8'h1c, 32'hffffffff);
		rdc(8'h1c, 32'hf1ff0fbf);
		for (int l = 1; l < 32; l++)
		begin
			xfer(1'b1, 8'h1c, l);
			@(posedge clk_in);
			chk(dsz, l > 15 ? 2 : l > 7 ? 1 : 0);
		end
		xfer(1'b1, 8'h04, 32'h4);
		xfer(1'b1, 8'h18, 32'h8);
		xfer(1'b1, 8'h00, 32'h1);
		frame(32'h014001a7, 32'h3ca5, 1'b1, 9'd16, 32'ha53c);
		repeat (4) @(posedge clk_in);
		rdc(8'h40, 32'h00010403);
		rdc(8'h40, 32'h00010003);
		xfer(1'b1, 8'h34, 32'h00b1);
		frame(32'h10a00007, 32'h0, 1'b0, 9'd17, 32'h11a00);
		md <= 1'b1;
		frame(32'h00400007, 32'h1e, 1'b0, 9'd8, 32'h78);
		final_report();
	end
endmodule

// >>> bench/sync_serial_tx_properties.sv
// Port assertions for the serial transmitter
`timescale 1ns/1ps
module sync_serial_tx_properties
	import sync_serial_tx_pkg::*;
(
	// Clock and reset
	input logic clk_in,
	input logic resetn_in,
	// Register bus
	input apb_req_s apb_in,
	input apb_rsp_s apb_out,
	input logic [31:0] received_word_in,
	// Pins
	input logic [1:0] dma_size_out,
	input logic tx_clock_oe_out,
	input logic frame_sync_out,
	input logic frame_sync_oe_out,
	input logic tx_data_out,
	input logic tx_data_oe_out,
	input logic multidrive_in
);
	logic acc;
	logic wrx;
	logic rdx;
	transmit_frame_mode_s fm_q;
	transmit_clock_mode_s cm_q;
	logic [7:0] dv_q;
	logic [15:0] hi_q;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	assign acc = apb_in.psel & apb_in.penable & apb_out.pready;
	assign wrx = acc & apb_in.pwrite;
	assign rdx = acc & !apb_in.pwrite;
	// Shadow of written setup and sync high time
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			fm_q <= '0;
			cm_q <= '0;
			dv_q <= 8'h0;
			hi_q <= 16'h0;
		end
		else
		begin
			hi_q <= frame_sync_out ? hi_q + 16'h1 : 16'h0;
			if (wrx && apb_in.paddr == 8'h1c)
				fm_q <= apb_in.pwdata & 32'hf1ff0fbf;
			if (wrx && apb_in.paddr == 8'h18)
				cm_q <= apb_in.pwdata & 32'hffff0fff;
			if (wrx && apb_in.paddr == 8'h04)
				dv_q <= apb_in.pwdata[7:0];
		end
	end
	AST_MD_OE: assert property (multidrive_in |-> tx_data_oe_out == tx_data_out)
		else $error("data enable on while driving zero");
	AST_FS_OE: assert property ($stable(fm_q) |->
		frame_sync_oe_out == (fm_q.sync_output_sel inside {[3'h1:3'h5]}))
		else $error("sync pin direction wrong");
	AST_DMA: assert property ($stable(fm_q) |-> dma_size_out ==
		(fm_q.word_bit_length > 5'd15 ? 2'h2 : fm_q.word_bit_length > 5'd7 ? 2'h1 : 2'h0))
		else $error("transfer size wrong");
	AST_CKO: assert property ($stable(cm_q) && cm_q.clock_output_mode inside {3'h0, 3'h1}
		|-> tx_clock_oe_out == cm_q.clock_output_mode[0])
		else $error("clock pin direction wrong");
	AST_IDLE: assert property ($stable(fm_q) && fm_q.sync_output_sel == 3'h4
		&& !frame_sync_out && !$past(frame_sync_out) |-> tx_data_out == fm_q.idle_data_level)
		else $error("idle data level wrong");
	AST_PULSE: assert property ($fell(frame_sync_out) && $stable(fm_q)
		&& fm_q.sync_output_sel == 3'h2 && cm_q.clock_source_sel == 2'h0
		|-> hi_q == (16'({fm_q.sync_length_upper, fm_q.sync_length_lower}) + 16'h1)
		* 16'({dv_q, 1'b0}))
		else $error("sync pulse length wrong");
	AST_RHR: assert property (rdx && apb_in.paddr == 8'h20
		|-> apb_out.prdata == $past(received_word_in))
		else $error("receive holding read wrong");
	AST_TRANSMIT_FRAME_MODE: assert property (rdx && apb_in.paddr == 8'h1c |-> apb_out.prdata == fm_q)
		else $error("frame mode read wrong");
	AST_ERR: assert property (acc && apb_in.paddr == 8'h10 |-> apb_out.pslverr)
		else $error("no error on unmapped address");
endmodule
bind sync_serial_transmitter sync_serial_tx_properties sync_serial_tx_properties_inst (
	.clk_in, .resetn_in, .apb_in, .apb_out, .received_word_in, .dma_size_out,
	.tx_clock_oe_out, .frame_sync_out, .frame_sync_oe_out, .tx_data_out, .tx_data_oe_out,
	.multidrive_in
);

// >>> hw/sync_serial_transmitter.sv
// Transmit side of a synchronous serial controller with an APB register slave
// Notes on behaviour
// RQ1: Nonzero start delay waits that many periods
// RQ2: Delay also applies to receive start
// RQ3: Mode 0 starts on holding write
// RQ4: Start selection decodes codes zero to seven
// RQ5: Gating continuous, frame-sync low, or high
// RQ6: Inversion picks shift and sample edges
// RQ7: Inversion never touches the clock pin
// RQ8: Clock pin input, continuous, or transfer only
// RQ9: Clock source divided, receive pin, transmit pin
// RQ10: Edge select chooses sync flag edge
// RQ11: Sync data shifted out during frame sync
// RQ12: Frame-sync pin output shape selection
// RQ13: Sync length joins upper and lower nibble
// RQ14: Sync pulse lasts length plus one
// RQ15: Sync length sets sync data bits
// RQ16: Frame sends words field plus one
// RQ17: Bit order bit selects MSB first
// RQ18: Idle data pin carries default level
// RQ19: Multi-drive pin enabled only when one
// RQ20: Word holds length field plus one bits
// RQ21: Length field selects DMA transfer size
// RQ22: Periodic sync every two times divider+1
// RQ23: Sync flag cleared by status read
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "sync_serial_tx_map.svh"
module sync_serial_transmitter
	import sync_serial_tx_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Register bus
	input wire apb_req_s apb_in,
	output apb_rsp_s apb_out,
	// Receiver side
	input wire logic rx_start_in,
	input wire logic [31:0] received_word_in,
	// Peripheral DMA
	output logic dma_req_out,
	output logic [1:0] dma_size_out,
	// Clock pins
	input wire logic rx_clock_in,
	input wire logic tx_clock_in,
	output logic tx_clock_out,
	output logic tx_clock_oe_out,
	// Frame sync pin
	input wire logic frame_sync_in,
	output logic frame_sync_out,
	output logic frame_sync_oe_out,
	// Data pin
	output logic tx_data_out,
	output logic tx_data_oe_out,
	input wire logic multidrive_in
);

	tx_state_s s_q;
	tx_state_s s_d;
	transmit_clock_mode_s cm;
	transmit_frame_mode_s fm;
	logic [7:0] fs_len;
	logic sel_lvl;
	logic gate_ok;
	logic clk_rise;
	logic clk_fall;
	logic shift_en;
	logic samp_en;
	logic fs_oe;
	logic fs_lvl;
	logic go;
	logic tick;
	logic begin_frame;
	logic setup;
	logic acc;
	logic hit;
	logic busy;
	logic [31:0] rd;
	logic [7:0] sidx;

	assign cm = s_q.transmit_clock_mode;
	assign fm = s_q.transmit_frame_mode;
	// RQ13 joined sync length
	assign fs_len = {fm.sync_length_upper, fm.sync_length_lower};
	assign setup = apb_in.psel & ~apb_in.penable;
	assign acc = apb_in.psel & apb_in.penable;
	assign busy = (s_q.st == ST_SYNC) | (s_q.st == ST_DATA);
	// RQ12 pin drives for codes one to five
	assign fs_oe = (fm.sync_output_sel != 3'h0) & (fm.sync_output_sel <= `FS_TOGGLE);
	assign fs_lvl = fs_oe ? s_q.fs_q : s_q.fs_s2;

	// Transmit clock selection, gating and edge pick
	always_comb
	begin
		// RQ9 clock source decode
		case (cm.clock_source_sel)
			2'h0: sel_lvl = s_q.div_lvl;
			2'h1: sel_lvl = s_q.rck_s2;
			2'h2: sel_lvl = s_q.tck_s2;
			default: sel_lvl = 1'b0;
		endcase
		// RQ5 gating by frame-sync level
		case (cm.clock_gating_sel)
			2'h0: gate_ok = 1'b1;
			2'h1: gate_ok = ~fs_lvl;
			2'h2: gate_ok = fs_lvl;
			default: gate_ok = 1'b0;
		endcase
		clk_rise = sel_lvl & ~s_q.clk_prev & gate_ok;
		clk_fall = ~sel_lvl & s_q.clk_prev & gate_ok;
		// RQ6 inversion swaps shift and sample edge
		shift_en = cm.clock_invert ? clk_rise : clk_fall;
		samp_en = cm.clock_invert ? clk_fall : clk_rise;
	end

	// Start condition decode
	always_comb
	begin
		// RQ4 start selection
		case (cm.start_sel)
			`START_CONT: go = 1'b1;
			`START_RX: go = s_q.rx_seen;
			`START_LOW: go = ~s_q.fs_samp;
			`START_HIGH: go = s_q.fs_samp;
			`START_FALL: go = s_q.fall_seen;
			`START_RISE: go = s_q.rise_seen;
			`START_CHANGE: go = s_q.rise_seen | s_q.fall_seen;
			`START_EDGE: go = s_q.rise_seen | s_q.fall_seen;
			default: go = 1'b0;
		endcase
	end

	// Register read decode
	always_comb
	begin
		rd = 32'h0;
		hit = 1'b1;
		case (apb_in.paddr)
			`OFF_CONTROL: rd = 32'h0;
			`OFF_CLOCK_DIV: rd = {24'h0, s_q.cdiv};
			`OFF_TX_CLOCK_MODE: rd = s_q.transmit_clock_mode;
			`OFF_TX_FRAME_MODE: rd = s_q.transmit_frame_mode;
			`OFF_RX_HOLDING: rd = received_word_in;
			`OFF_TX_HOLDING: rd = 32'h0;
			`OFF_TX_SYNC_HOLDING: rd = {16'h0, s_q.tsh};
			`OFF_STATUS:
			begin
				rd[`STAT_TX_READY] = ~s_q.thr_full;
				rd[`STAT_TX_EMPTY] = ~s_q.thr_full & (s_q.st == ST_IDLE);
				rd[`STAT_TX_SYNC] = s_q.transmit_sync_flag;
				rd[`STAT_TX_EN] = s_q.txen;
			end
			default: hit = 1'b0;
		endcase
	end

	// Next state
	always_comb
	begin
		s_d = s_q;
		tick = 1'b0;
		begin_frame = 1'b0;
		sidx = 8'h0;
		// Pin synchronisers
		s_d.tck_s1 = tx_clock_in;
		s_d.tck_s2 = s_q.tck_s1;
		s_d.rck_s1 = rx_clock_in;
		s_d.rck_s2 = s_q.rck_s1;
		s_d.fs_s1 = frame_sync_in;
		s_d.fs_s2 = s_q.fs_s1;
		// Divided clock, half period of cdiv cycles
		if (s_q.cdiv == 8'h00)
		begin
			s_d.div_cnt = 8'h00;
			s_d.div_lvl = 1'b0;
		end
		else if (s_q.div_cnt == s_q.cdiv - 8'h01)
		begin
			s_d.div_cnt = 8'h00;
			s_d.div_lvl = ~s_q.div_lvl;
		end
		else
		begin
			s_d.div_cnt = s_q.div_cnt + 8'h01;
		end
		s_d.clk_prev = sel_lvl;

		if (shift_en)
		begin
			s_d.rise_seen = 1'b0;
			s_d.fall_seen = 1'b0;
			s_d.rx_seen = 1'b0;
			// RQ22 periodic frame sync
			if (cm.period == 8'h00)
			begin
				s_d.per_cnt = 9'h000;
			end
			else if (s_q.per_cnt == {cm.period, 1'b1})
			begin
				s_d.per_cnt = 9'h000;
				tick = 1'b1;
			end
			else
			begin
				s_d.per_cnt = s_q.per_cnt + 9'h001;
			end
			// RQ14 pulse of length plus one periods
			if (s_q.fs_on)
			begin
				if (s_q.fs_cnt == 8'h00)
				begin
					s_d.fs_on = 1'b0;
				end
				else
				begin
					s_d.fs_cnt = s_q.fs_cnt - 8'h01;
				end
			end
			if (tick)
			begin
				s_d.fs_on = 1'b1;
				s_d.fs_cnt = fs_len;
			end
			case (s_q.st)
				ST_IDLE:
				begin
					// RQ18 idle level on data pin
					s_d.data_q = fm.idle_data_level;
					// RQ3 continuous start once data waits
					if (s_q.txen & ~s_q.dis_pend & s_q.thr_full & go)
					begin
						// RQ1 optional start delay
						if (cm.start_delay_cycles == 8'h00)
						begin
							begin_frame = 1'b1;
						end
						else
						begin
							s_d.st = ST_DELAY;
							s_d.dly = cm.start_delay_cycles;
						end
					end
				end
				ST_DELAY:
				begin
					s_d.data_q = fm.idle_data_level;
					// RQ2 delay counted for every start source
					if (s_q.dly == 8'h01)
					begin
						begin_frame = 1'b1;
					end
					else
					begin
						s_d.dly = s_q.dly - 8'h01;
					end
				end
				default:
				begin
				end
			endcase
			// Last bit has stood a full period, frame ends now
			if ((s_q.st == ST_DATA) & (s_q.sync_n == 8'hff))
			begin
				s_d.st = ST_IDLE;
			end
			if (begin_frame)
			begin
				s_d.shreg = s_q.transmit_holding;
				s_d.thr_full = 1'b0;
				s_d.word_n = 4'h0;
				s_d.bit_n = 5'h00;
				s_d.sync_n = 8'h00;
				s_d.fs_on = 1'b1;
				s_d.fs_cnt = fs_len;
				s_d.fs_tgl = ~s_q.fs_tgl;
				if (fm.sync_data_insert_en | (fm.sync_output_sel == `FS_NEG_PULSE)
					| (fm.sync_output_sel == `FS_POS_PULSE))
				begin
					s_d.st = ST_SYNC;
				end
				else
				begin
					s_d.st = ST_DATA;
				end
			end
			case (s_d.st)
				ST_SYNC:
				begin
					sidx = fm.msb_first ? fs_len - s_d.sync_n : s_d.sync_n;
					// RQ11 sync data or default level
					if (fm.sync_data_insert_en)
					begin
						s_d.data_q = (sidx < 8'h10) ? s_q.tsh[sidx[3:0]] : 1'b0;
					end
					else
					begin
						s_d.data_q = fm.idle_data_level;
					end
					// RQ15 sync bit count
					if (s_d.sync_n == fs_len)
					begin
						s_d.st = ST_DATA;
						s_d.sync_n = 8'h00;
					end
					else
					begin
						s_d.sync_n = s_d.sync_n + 8'h01;
					end
				end
				ST_DATA:
				begin
					// RQ17 bit order
					if (fm.msb_first)
					begin
						s_d.data_q = s_d.shreg[fm.word_bit_length - s_d.bit_n];
					end
					else
					begin
						s_d.data_q = s_d.shreg[s_d.bit_n];
					end
					// RQ20 word of length plus one bits
					if (s_d.bit_n == fm.word_bit_length)
					begin
						// RQ16 words per frame plus one
						if (s_d.word_n == fm.words_per_frame)
						begin
							s_d.sync_n = 8'hff;
						end
						else if (s_d.thr_full)
						begin
							s_d.shreg = s_q.transmit_holding;
							s_d.thr_full = 1'b0;
							s_d.word_n = s_d.word_n + 4'h1;
							s_d.bit_n = 5'h00;
						end
						else
						begin
							s_d.sync_n = 8'hff;
						end
					end
					else
					begin
						s_d.bit_n = s_d.bit_n + 5'h01;
					end
				end
				default:
				begin
				end
			endcase
		end

		// RQ18 data pin rests at default level
		if ((s_d.st == ST_IDLE) | (s_d.st == ST_DELAY))
		begin
			s_d.data_q = fm.idle_data_level;
		end

		// Frame-sync sampling on the sample edge
		if (samp_en)
		begin
			s_d.fs_samp = fs_lvl;
			if (fs_lvl & ~s_q.fs_samp)
			begin
				s_d.rise_seen = 1'b1;
			end
			if (~fs_lvl & s_q.fs_samp)
			begin
				s_d.fall_seen = 1'b1;
			end
		end
		if (rx_start_in)
		begin
			s_d.rx_seen = 1'b1;
		end

		// Disable takes effect once no data is in flight
		if (s_q.dis_pend & (s_q.st == ST_IDLE))
		begin
			s_d.txen = 1'b0;
			s_d.dis_pend = 1'b0;
		end

		// APB access
		if (setup)
		begin
			s_d.rdata = apb_in.pwrite ? 32'h0 : rd;
			s_d.err = ~hit;
		end
		if (acc & apb_in.pwrite & ~s_q.err)
		begin
			case (apb_in.paddr)
				`OFF_CONTROL:
				begin
					if (apb_in.pwdata[`CTRL_TX_ENABLE])
					begin
						s_d.txen = 1'b1;
						s_d.dis_pend = 1'b0;
					end
					if (apb_in.pwdata[`CTRL_TX_DISABLE])
					begin
						s_d.dis_pend = 1'b1;
					end
				end
				`OFF_CLOCK_DIV: s_d.cdiv = apb_in.pwdata[7:0];
				`OFF_TX_CLOCK_MODE: s_d.transmit_clock_mode = transmit_clock_mode_s'(apb_in.pwdata & `MASK_TX_CLOCK_MODE);
				`OFF_TX_FRAME_MODE: s_d.transmit_frame_mode = transmit_frame_mode_s'(apb_in.pwdata & `MASK_TX_FRAME_MODE);
				`OFF_TX_HOLDING:
				begin
					s_d.transmit_holding = apb_in.pwdata;
					s_d.thr_full = 1'b1;
				end
				`OFF_TX_SYNC_HOLDING: s_d.tsh = apb_in.pwdata[15:0];
				default:
				begin
				end
			endcase
		end
		// RQ23 read clears the sync flag
		if (acc & ~apb_in.pwrite & (apb_in.paddr == `OFF_STATUS))
		begin
			s_d.transmit_sync_flag = 1'b0;
		end
		// RQ10 flag edge select, set wins over clear
		s_d.fs_lvl_prev = fs_lvl;
		if (fm.sync_edge_sel ? (~fs_lvl & s_q.fs_lvl_prev) : (fs_lvl & ~s_q.fs_lvl_prev))
		begin
			s_d.transmit_sync_flag = 1'b1;
		end

		// RQ12 frame-sync pin shape
		case (s_d.transmit_frame_mode.sync_output_sel)
			`FS_NEG_PULSE: s_d.fs_q = ~s_d.fs_on;
			`FS_POS_PULSE: s_d.fs_q = s_d.fs_on;
			`FS_LOW_XFER: s_d.fs_q = ~(s_d.st == ST_DATA);
			`FS_HIGH_XFER: s_d.fs_q = (s_d.st == ST_DATA);
			`FS_TOGGLE: s_d.fs_q = s_d.fs_tgl;
			default: s_d.fs_q = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign apb_out.prdata = s_q.rdata;
	assign apb_out.pready = 1'b1;
	assign apb_out.pslverr = s_q.err & acc;
	assign dma_req_out = s_q.txen & ~s_q.thr_full;
	// RQ21 DMA transfer size from word length
	assign dma_size_out = (fm.word_bit_length <= 5'h07) ? 2'h0 :
		(fm.word_bit_length <= 5'h0f) ? 2'h1 : 2'h2;
	// RQ7 pin clock taken before inversion
	assign tx_clock_out = s_q.clk_prev;
	// RQ8 clock pin drive mode
	assign tx_clock_oe_out = (cm.clock_output_mode == 3'h1)
		| ((cm.clock_output_mode == 3'h2) & busy);
	assign frame_sync_out = s_q.fs_q;
	assign frame_sync_oe_out = fs_oe;
	assign tx_data_out = s_q.data_q;
	// RQ19 multi-drive enables only a one
	assign tx_data_oe_out = ~multidrive_in | s_q.data_q;

endmodule

// >>> hw/sync_serial_tx_map.svh
// Register offsets, field positions, codes and reset values of the transmitter
`ifndef SYNC_SERIAL_TX_MAP_SVH
`define SYNC_SERIAL_TX_MAP_SVH
`define OFF_CONTROL 8'h00
`define OFF_CLOCK_DIV 8'h04
`define OFF_TX_CLOCK_MODE 8'h18
`define OFF_TX_FRAME_MODE 8'h1c
`define OFF_RX_HOLDING 8'h20
`define OFF_TX_HOLDING 8'h24
`define OFF_TX_SYNC_HOLDING 8'h34
`define OFF_STATUS 8'h40
`define RST_TX_CLOCK_MODE 32'h00000000
`define RST_TX_FRAME_MODE 32'h00000000
`define MASK_TX_CLOCK_MODE 32'hffff0fff
`define MASK_TX_FRAME_MODE 32'hf1ff0fbf
`define CTRL_TX_ENABLE 0
`define CTRL_TX_DISABLE 1
`define STAT_TX_READY 0
`define STAT_TX_EMPTY 1
`define STAT_TX_SYNC 10
`define STAT_TX_EN 16
`define START_CONT 4'h0
`define START_RX 4'h1
`define START_LOW 4'h2
`define START_HIGH 4'h3
`define START_FALL 4'h4
`define START_RISE 4'h5
`define START_CHANGE 4'h6
`define START_EDGE 4'h7
`define FS_NEG_PULSE 3'h1
`define FS_POS_PULSE 3'h2
`define FS_LOW_XFER 3'h3
`define FS_HIGH_XFER 3'h4
`define FS_TOGGLE 3'h5
`endif

// >>> hw/sync_serial_tx_pkg.sv
// Types shared by the serial transmitter
package sync_serial_tx_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_SYNC = 2'b10,
		ST_DATA = 2'b11
	} tx_state_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;
	typedef struct packed {
		logic [7:0] period;
		logic [7:0] start_delay_cycles;
		logic [3:0] rsv0;
		logic [3:0] start_sel;
		logic [1:0] clock_gating_sel;
		logic clock_invert;
		logic [2:0] clock_output_mode;
		logic [1:0] clock_source_sel;
	} transmit_clock_mode_s;
	typedef struct packed {
		logic [3:0] sync_length_upper;
		logic [2:0] rsv2;
		logic sync_edge_sel;
		logic sync_data_insert_en;
		logic [2:0] sync_output_sel;
		logic [3:0] sync_length_lower;
		logic [3:0] rsv1;
		logic [3:0] words_per_frame;
		logic msb_first;
		logic rsv0;
		logic idle_data_level;
		logic [4:0] word_bit_length;
	} transmit_frame_mode_s;
	typedef struct packed {
		transmit_clock_mode_s transmit_clock_mode;
		transmit_frame_mode_s transmit_frame_mode;
		logic [7:0] cdiv;
		logic [15:0] tsh;
		logic [31:0] transmit_holding;
		logic thr_full;
		logic [31:0] shreg;
		tx_state_e st;
		logic [7:0] dly;
		logic [4:0] bit_n;
		logic [7:0] sync_n;
		logic [3:0] word_n;
		logic fs_on;
		logic [7:0] fs_cnt;
		logic [8:0] per_cnt;
		logic fs_tgl;
		logic fs_q;
		logic data_q;
		logic txen;
		logic dis_pend;
		logic transmit_sync_flag;
		logic tck_s1;
		logic tck_s2;
		logic rck_s1;
		logic rck_s2;
		logic fs_s1;
		logic fs_s2;
		logic clk_prev;
		logic fs_samp;
		logic rise_seen;
		logic fall_seen;
		logic rx_seen;
		logic fs_lvl_prev;
		logic [7:0] div_cnt;
		logic div_lvl;
		logic [31:0] rdata;
		logic err;
	} tx_state_s;
endpackage
